// ===== hw/usb_irq_pkg.sv
// Constants, field layout and bus carriers for the USB interrupt-pending flag block.
// Assumes every event input comes from USB core logic clocked by the same clk.
// Operation
// - Pending flags for OUT endpoints 3,2,1
// - Reading OUT flags returns then clears
// - Unused OUT flag bits read zero
// - Bus reset signaling sets bit 2
// - Resume sets bit 1 only while suspended
// - Reading common flags clears them
package usb_irq_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // Register map, byte offsets in the indirect register space
  localparam logic [7:0] OUT_FLAGS_ADDR = 8'h04;
  localparam logic [7:0] COMMON_FLAGS_ADDR = 8'h06;
  localparam logic [7:0] OUT_MASK_ADDR = 8'h09;
  localparam logic [7:0] COMMON_MASK_ADDR = 8'h0b;
  localparam logic [7:0] CONTROL_ADDR = 8'h0e;
  localparam logic [7:0] STATE_ADDR = 8'h0f;

  // Field positions
  localparam int unsigned OUT_EP1_BIT = 1;
  localparam int unsigned OUT_EP2_BIT = 2;
  localparam int unsigned OUT_EP3_BIT = 3;
  localparam int unsigned SUSPEND_BIT = 0;
  localparam int unsigned RESUME_BIT = 1;
  localparam int unsigned BUS_RESET_BIT = 2;
  localparam int unsigned SOF_BIT = 3;
  localparam int unsigned SUSPEND_DETECT_EN_BIT = 0;
  localparam int unsigned STATE_SUSPENDED_BIT = 0;
  localparam int unsigned STATE_IRQ_BIT = 1;

  // Implemented bits of each register
  localparam logic [7:0] OUT_VALID_BITS = 8'h0e;
  localparam logic [7:0] COMMON_VALID_BITS = 8'h0f;
  localparam logic [7:0] CONTROL_VALID_BITS = 8'h01;

  // Reset values
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] OUT_MASK_RESET = 8'h0e;
  localparam logic [7:0] COMMON_MASK_RESET = 8'h06;
  localparam logic [7:0] CONTROL_RESET = 8'h01;
  localparam logic [7:0] READ_ZERO = 8'h00;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic write;
    logic read;
  } reg_bus_req_t;

  typedef struct packed {
    logic [3:1] out_ep_done;
    logic bus_reset_signal;
    logic resume_signal;
    logic suspend_signal;
    logic sof_token;
    logic sof_missed;
    logic core_suspended;
  } usb_events_t;

  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] out_mask;
    logic [DATA_W-1:0] common_mask;
    logic [DATA_W-1:0] control;
    logic bus_reset_prev;
    logic resume_prev;
    logic suspend_prev;
    logic irq;
  } top_state_t;

endpackage : usb_irq_pkg

// ===== hw/flag_bank.sv
// One register of sticky pending flags with clear-on-read and an enable mask.
// Assumes set pulses and the clear strobe are on clk; a set in the clearing cycle wins.
`timescale 1ns/1ps
`default_nettype none
module flag_bank #(
  parameter int unsigned W = 8,
  parameter logic [W-1:0] VALID = '1,
  parameter logic [W-1:0] RESET_VALUE = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] set_bits,
  input wire logic clear,
  input wire logic [W-1:0] mask,
  output logic [W-1:0] flags,
  output logic [W-1:0] flags_next,
  output logic pending_next
);
  typedef struct packed {
    logic [W-1:0] flags;
  } bank_state_t;

  bank_state_t state_reg;
  bank_state_t state_next;

  always_comb begin
    state_next = state_reg;
    // Clear first, then set, so an event in the read cycle is kept
    if (clear) begin
      state_next.flags = '0;
    end
    state_next.flags = (state_next.flags | set_bits) & VALID;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= '{flags: RESET_VALUE};
    end else begin
      state_reg <= state_next;
    end
  end

  assign flags = state_reg.flags;
  assign flags_next = state_next.flags;
  assign pending_next = |(state_next.flags & mask);
endmodule : flag_bank
`default_nettype wire

// ===== hw/usb_irq_pending_flags.sv
// OUT-endpoint and common bus-event pending flags of the USB function core, with
// enable masks, a control register and one level interrupt.
// Assumes the bus master and the USB core share clk; reads are answered next cycle.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module usb_irq_pending_flags (
  input wire logic clk,
  input wire logic rst,
  input wire usb_irq_pkg::reg_bus_req_t bus,
  output logic [usb_irq_pkg::DATA_W-1:0] rdata,
  input wire usb_irq_pkg::usb_events_t events,
  output logic suspend_detect_enable,
  output logic irq
);
  import usb_irq_pkg::*;

  top_state_t state_reg;
  top_state_t state_next;

  logic [DATA_W-1:0] out_set;
  logic [DATA_W-1:0] common_set;
  logic [DATA_W-1:0] out_flags;
  logic [DATA_W-1:0] common_flags;
  logic out_pending_next;
  logic common_pending_next;
  logic out_clear;
  logic common_clear;
  logic bus_reset_rise;
  logic resume_rise;
  logic suspend_rise;

  // Level signaling only raises a flag on its start, so a long bus reset
  // does not keep re-arming the flag after software has read it.
  assign bus_reset_rise = events.bus_reset_signal & ~state_reg.bus_reset_prev;
  assign resume_rise = events.resume_signal & ~state_reg.resume_prev;
  assign suspend_rise = events.suspend_signal & ~state_reg.suspend_prev;

  always_comb begin
    out_set = '0;
    out_set[OUT_EP1_BIT] = events.out_ep_done[1];
    out_set[OUT_EP2_BIT] = events.out_ep_done[2];
    out_set[OUT_EP3_BIT] = events.out_ep_done[3];
  end

  always_comb begin
    common_set = '0;
    common_set[BUS_RESET_BIT] = bus_reset_rise;
    // Resume is only meaningful while the core is suspended
    common_set[RESUME_BIT] = resume_rise & events.core_suspended;
    common_set[SOF_BIT] = events.sof_token | events.sof_missed;
    common_set[SUSPEND_BIT] = suspend_rise & state_reg.control[SUSPEND_DETECT_EN_BIT];
  end

  assign out_clear = bus.read && (bus.addr == OUT_FLAGS_ADDR);
  assign common_clear = bus.read && (bus.addr == COMMON_FLAGS_ADDR);

  flag_bank #(
    .W(DATA_W),
    .VALID(OUT_VALID_BITS),
    .RESET_VALUE(FLAGS_RESET)
  ) out_bank (
    .clk(clk),
    .rst(rst),
    .set_bits(out_set),
    .clear(out_clear),
    .mask(state_reg.out_mask),
    .flags(out_flags),
    .flags_next(),
    .pending_next(out_pending_next)
  );

  flag_bank #(
    .W(DATA_W),
    .VALID(COMMON_VALID_BITS),
    .RESET_VALUE(FLAGS_RESET)
  ) common_bank (
    .clk(clk),
    .rst(rst),
    .set_bits(common_set),
    .clear(common_clear),
    .mask(state_reg.common_mask),
    .flags(common_flags),
    .flags_next(),
    .pending_next(common_pending_next)
  );

  always_comb begin
    state_next = state_reg;
    state_next.bus_reset_prev = events.bus_reset_signal;
    state_next.resume_prev = events.resume_signal;
    state_next.suspend_prev = events.suspend_signal;

    // Writes; flag registers are read-only and ignore writes
    if (bus.write) begin
      if (bus.addr == OUT_MASK_ADDR) begin
        state_next.out_mask = bus.wdata & OUT_VALID_BITS;
      end else if (bus.addr == COMMON_MASK_ADDR) begin
        state_next.common_mask = bus.wdata & COMMON_VALID_BITS;
      end else if (bus.addr == CONTROL_ADDR) begin
        state_next.control = bus.wdata & CONTROL_VALID_BITS;
      end
    end

    // Read data holds only in the cycle after the strobe; flags show the
    // value from before the clear that the same read causes.
    state_next.rdata = READ_ZERO;
    if (bus.read) begin
      if (bus.addr == OUT_FLAGS_ADDR) begin
        state_next.rdata = out_flags & OUT_VALID_BITS;
      end else if (bus.addr == COMMON_FLAGS_ADDR) begin
        state_next.rdata = common_flags & COMMON_VALID_BITS;
      end else if (bus.addr == OUT_MASK_ADDR) begin
        state_next.rdata = state_reg.out_mask;
      end else if (bus.addr == COMMON_MASK_ADDR) begin
        state_next.rdata = state_reg.common_mask;
      end else if (bus.addr == CONTROL_ADDR) begin
        state_next.rdata = state_reg.control;
      end else if (bus.addr == STATE_ADDR) begin
        state_next.rdata[STATE_SUSPENDED_BIT] = events.core_suspended;
        state_next.rdata[STATE_IRQ_BIT] = state_reg.irq;
      end
    end

    // Registered from next-cycle flag values so irq tracks the flags exactly
    state_next.irq = out_pending_next | common_pending_next;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= '{
        rdata: READ_ZERO,
        out_mask: OUT_MASK_RESET,
        common_mask: COMMON_MASK_RESET,
        control: CONTROL_RESET,
        bus_reset_prev: 1'b0,
        resume_prev: 1'b0,
        suspend_prev: 1'b0,
        irq: 1'b0
      };
    end else begin
      state_reg <= state_next;
    end
  end

  assign rdata = state_reg.rdata;
  assign irq = state_reg.irq;
  assign suspend_detect_enable = state_reg.control[SUSPEND_DETECT_EN_BIT];
endmodule : usb_irq_pending_flags
`default_nettype wire

// ===== test/usb_irq_sva.sv
// Port-level checks of the pending-flag block.
// Assumes one clock and read data standing one cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none
module usb_irq_sva (
  input wire logic clk,
  input wire logic rst,
  input wire usb_irq_pkg::reg_bus_req_t bus,
  input wire logic [usb_irq_pkg::DATA_W-1:0] rdata,
  input wire usb_irq_pkg::usb_events_t events
);
  import usb_irq_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_rd_out;
    bus.read && bus.addr == OUT_FLAGS_ADDR;
  endsequence
  sequence s_rd_cm;
    bus.read && bus.addr == COMMON_FLAGS_ADDR;
  endsequence
  // Events of the cycle before the read must show in its answer
  a_out_ep_set: assert property (s_rd_out ##0 !$past(rst) |=>
    (rdata[3:1] & $past(events.out_ep_done, 2)) == $past(events.out_ep_done, 2))
    else $error("OUT flag lost");
  a_out_rd_clear: assert property ((s_rd_out ##0 events.out_ep_done == 3'h0) ##1 s_rd_out |=>
    rdata == 8'h00) else $error("OUT flags not cleared by read");
  a_out_unused_zero: assert property (s_rd_out |=> (rdata & 8'hf1) == 8'h00)
    else $error("unused OUT bits not zero");
  a_bus_reset_set: assert property ($rose(events.bus_reset_signal) ##1 s_rd_cm |=> rdata[2])
    else $error("bus reset flag missing");
  // A resume edge outside suspend, between two reads, must not reach the answer
  a_resume_only_susp: assert property ((s_rd_cm ##0 !(events.resume_signal && events.core_suspended))
    ##1 ($rose(events.resume_signal) && !events.core_suspended) ##1 s_rd_cm |=> !rdata[1])
    else $error("resume flag without suspend");
  a_cm_rd_clear: assert property ((s_rd_cm ##0 events == '0) ##1 s_rd_cm |=> rdata == 8'h00)
    else $error("common flags not cleared by read");
  a_sof_set: assert property ((events.sof_token || events.sof_missed) ##1 s_rd_cm |=> rdata[3])
    else $error("SOF flag missing");
endmodule : usb_irq_sva
bind usb_irq_pending_flags usb_irq_sva chk (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .events(events));
`default_nettype wire

// ===== test/usb_host_model.sv
// Host side of the USB bus: turns bench requests into bus signaling.
// Assumes requests change after a rising edge; signaling follows one edge later.
`timescale 1ns/1ps
`default_nettype none
module usb_host_model (
  input wire logic clk,
  input wire usb_irq_pkg::usb_events_t req,
  output var usb_irq_pkg::usb_events_t ev
);
  import usb_irq_pkg::*;
  always_ff @(posedge clk) begin
    ev <= req;
  end
endmodule : usb_host_model
`default_nettype wire

// ===== test/test_usb_irq_pending_flags.sv
// Bench for the pending-flag block: reads queue their expected data, a monitor compares.
// Assumes the host model delays requested signaling by one edge.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module test_usb_irq_pending_flags;
  import usb_irq_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  reg_bus_req_t bus = '0;
  usb_events_t req = '0;
  usb_events_t events;
  logic [7:0] rdata;
  logic irq;
  logic sde;
  logic rd_d = 1'b0;
  logic [7:0] q[$];
  logic [7:0] x, p, m;
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [8:0] ev_tab[6] = '{9'h020, 9'h011, 9'h010, 9'h008, 9'h004, 9'h002};
  logic [7:0] fl_tab[6] = '{8'h04, 8'h02, 8'h00, 8'h01, 8'h08, 8'h08};
  logic [7:0] ad_tab[7] = '{8'h04, 8'h06, 8'h09, 8'h0b, 8'h0e, 8'h0f, 8'h20};
  logic [7:0] rv_tab[7] = '{8'h00, 8'h00, 8'h0e, 8'h06, 8'h01, 8'h00, 8'h00};
  always #4 clk = ~clk;
  usb_irq_pending_flags dut (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .events(events),
    .suspend_detect_enable(sde), .irq(irq));
  usb_host_model host (.clk(clk), .req(req), .ev(events));
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    bus.read <= 1'b1;
    bus.write <= 1'b0;
    bus.addr <= a;
    q.push_back(e);
    @(posedge clk);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus.write <= 1'b1;
    bus.read <= 1'b0;
    bus.addr <= a;
    bus.wdata <= d;
    @(posedge clk);
  endtask : wr
  task automatic idle(input int n);
    bus.read <= 1'b0;
    bus.write <= 1'b0;
    repeat (n) @(posedge clk);
  endtask : idle
  // Levels are looked at mid-cycle, away from the edge that launches them
  task automatic look(input logic e_irq, input logic e_sde);
    bus.read <= 1'b0;
    bus.write <= 1'b0;
    @(negedge clk);
    `CHK("irq", e_irq, irq)
    `CHK("suspend_detect_enable", e_sde, sde)
    @(posedge clk);
  endtask : look
  // One cycle of signaling, timed so the next read lands right after the flag sets
  task automatic pulse(input usb_events_t e);
    req <= e;
    idle(1);
    req <= '0;
    idle(1);
  endtask : pulse
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  always @(posedge clk) begin
    if (rd_d) begin
      x = q.pop_front();
      `CHK("rdata", x, rdata)
    end
    rd_d <= bus.read;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      give_verdict();
    end
  end
  initial begin
    void'($urandom(2));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) rd(ad_tab[i], rv_tab[i]);
    idle(2);
    $display("test reset_values done");
    p = $urandom & 8'h0e;
    m = $urandom;
    wr(8'h04, 8'hff);
    pulse(usb_events_t'({p[3:1], 6'h00}));
    rd(8'h04, p);
    rd(8'h04, 8'h00);
    wr(8'h09, m);
    rd(8'h09, m & 8'h0e);
    pulse(usb_events_t'(9'h1c0));
    rd(8'h0f, {6'h00, |(m & 8'h0e), 1'b0});
    rd(8'h04, 8'h0e);
    rd(8'h0f, 8'h00);
    idle(2);
    $display("test out_flags done");
    for (int i = 0; i < 6; i++) begin
      pulse(usb_events_t'(ev_tab[i]));
      rd(8'h06, fl_tab[i]);
      rd(8'h06, 8'h00);
      idle(1);
    end
    idle(2);
    $display("test common_flags done");
    // Resume edge lands between two reads while the core is awake
    req <= usb_events_t'(9'h010);
    rd(8'h06, 8'h00);
    req <= '0;
    idle(1);
    rd(8'h06, 8'h00);
    look(1'b0, 1'b1);
    wr(8'h0e, 8'h00);
    wr(8'h0b, 8'h08);
    look(1'b0, 1'b0);
    pulse(usb_events_t'(9'h008));
    rd(8'h06, 8'h00);
    pulse(usb_events_t'(9'h004));
    look(1'b1, 1'b0);
    rd(8'h06, 8'h08);
    look(1'b0, 1'b0);
    pulse(usb_events_t'(9'h020));
    look(1'b0, 1'b0);
    rd(8'h0b, 8'h08);
    rd(8'h06, 8'h04);
    idle(2);
    $display("test irq_control done");
    give_verdict();
  end
endmodule : test_usb_irq_pending_flags
`default_nettype wire
